/* src/gsrt_pkg.sv */
// package for the service-request, serial-poll and trigger block
// assumes one clock domain and a synchronous active-low reset
package gsrt_pkg;
  // register byte offsets
  localparam logic [7:0] GSRT_CTRL_OFS = 8'h00;
  localparam logic [7:0] GSRT_TRIG_OFS = 8'h04;
  localparam logic [7:0] GSRT_STAT_OFS = 8'h08;
  localparam logic [7:0] GSRT_EVENT_OFS = 8'h0C;
  localparam logic [7:0] GSRT_EVTRIG_OFS = 8'h10;
  // control register field positions
  localparam int GSRT_CTRL_RQS_BIT = 0;
  localparam int GSRT_CTRL_USR1_BIT = 1;
  localparam int GSRT_CTRL_USR2_BIT = 2;
  localparam int GSRT_CTRL_ANY_BIT = 3;
  localparam int GSRT_CTRL_VERB_BIT = 4;
  localparam int GSRT_CTRL_SWADDR_LSB = 8;
  // reset values; service request enable forced on at power-up
  localparam logic [31:0] GSRT_CTRL_RESET = 32'h0000_0001;
  // bus address bases
  localparam logic [7:0] GSRT_LISTEN_BASE = 8'h20;
  localparam logic [7:0] GSRT_TALK_BASE = 8'h40;
  localparam logic [7:0] GSRT_UNL = 8'h3F;
  localparam logic [7:0] GSRT_UNT = 8'h5F;
  // interface message codes
  localparam logic [7:0] GSRT_DCL = 8'h14;
  localparam logic [7:0] GSRT_SDC = 8'h04;
  localparam logic [7:0] GSRT_GET = 8'h08;
  localparam logic [7:0] GSRT_SPE = 8'h18;
  localparam logic [7:0] GSRT_SPD = 8'h19;
  localparam logic [7:0] GSRT_PPC = 8'h05;
  // status bytes: bit 6 is the request-service flag
  localparam logic [7:0] GSRT_STB_NONE = 8'h00;
  localparam logic [7:0] GSRT_STB_PWRON = 8'h41;
  localparam logic [7:0] GSRT_STB_ERR = 8'h61;
  localparam logic [7:0] GSRT_STB_STATUS = 8'h42;
  localparam logic [7:0] GSRT_STB_USR1 = 8'h43;
  localparam logic [7:0] GSRT_STB_USR2 = 8'h44;
  localparam logic [7:0] GSRT_STB_KEY = 8'h45;
  // event codes
  localparam logic [7:0] GSRT_EVC_PWRON = 8'h01;
  localparam logic [7:0] GSRT_EVC_ERR = 8'h02;
  localparam logic [7:0] GSRT_EVC_STATUS = 8'h03;
  localparam logic [7:0] GSRT_EVC_USR1 = 8'h04;
  localparam logic [7:0] GSRT_EVC_USR2 = 8'h05;
  localparam logic [7:0] GSRT_EVC_KEY = 8'h06;
  // number of event sources
  localparam int GSRT_NSRC = 6;
  // acquisition states
  typedef enum logic [1:0] {
    GSRT_ACQ_STOP = 2'b00,
    GSRT_ACQ_RUN = 2'b01,
    GSRT_ACQ_HOLD = 2'b10
  } gsrt_acq_t;
endpackage

/* src/gsrt_top.sv */
// service request, serial poll and group trigger logic of the bus port
// assumes bus lines arrive on aclk and keys asynchronous; AXI4-Lite on aclk
// Summary of operation
// R01: after poll enable, talk-addressed output carries the status byte
// R02: poll disable returns talker output to normal responses
// R03: reading the status byte in a poll releases the service request line
// R04: parallel poll is never answered; no poll response bit driven
// R05: group trigger acts only after a trigger setup was written
// R06: group trigger honoured only while listen-addressed
// R07: trigger setup holds stop, run or hold-next; trigger switches state
// R08: service request asserted only while request enable is on; a line already raised stays up when enable is cleared
// R09: request enable comes up on after every reset
// R10: status byte encodes the type of the requesting event
// R11: further pending requests raise the line again after a poll
// R12: pending request never stalls normal message traffic
// R13: event query gives numeric code; text flag only with verbose option
// R14: each user button has a mask bit; set bit lets a press request
// R15: user buttons report unique status byte and event code
// R16: any-key mask lets any display key raise a request
// R17: controller polls devices on seeing the request line
// R18: controller addresses device as listener, then talker, for answers
// R19: listen address is 32 plus switches, talk address 64 plus switches
// R20: device clear drops pending events except the power-on event
// R21: status byte latched at poll read start, held until handshake ends
//
// The address map and the AXI4-Lite slave port were decided locally.
module gsrt_top
  import gsrt_pkg::*;
(
  input wire logic aclk, // device clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] bus_cmd, // interface message byte with atn
  input wire logic bus_cmd_stb, // one-cycle strobe for bus_cmd
  input wire logic talk_rd_start, // talker starts sending a byte
  input wire logic talk_rd_done, // talker byte handshake complete
  input wire logic [7:0] resp_data, // normal response byte
  output logic [7:0] talk_data, // byte put on the bus
  output logic srq_o, // service request line drive, high asserts
  output logic srq_oe_n, // drive enable, low while driving
  output logic ppr_oe_n, // parallel poll response enable, never low
  input wire logic [4:0] addr_sw, // rear address switches
  input wire logic err_evt, // error event pulse
  input wire logic status_evt, // status change pulse
  input wire logic usr1_key, // user button 1 pin
  input wire logic usr2_key, // user button 2 pin
  input wire logic any_key, // any display key pin
  output gsrt_pkg::gsrt_acq_t acq_state, // acquisition state request
  output logic listening, // listen-addressed
  output logic talking, // talk-addressed
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  import gsrt_pkg::*;

  typedef struct packed {
    logic [2:0] sy1; // first synchroniser stage of keys
    logic [2:0] sy2; // second stage
    logic [2:0] sy3; // previous value for edge detect
    logic listen;
    logic talk;
    logic sp_mode;
    logic [GSRT_NSRC-1:0] pend;
    logic srq;
    logic [7:0] stb_hold;
    logic [2:0] cur_src;
    logic [7:0] out;
    logic [31:0] ctrl;
    logic trig_armed;
    logic [1:0] trig_state;
    gsrt_acq_t acq;
    logic [7:0] last_evc;
    logic [2:0] last_src;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gsrt_state_t;

  gsrt_state_t r;
  gsrt_state_t next_r;

  ////////////////////////////////////////////////////////////////////
  // lowest index pending source wins; power-on first
  function automatic logic [2:0] pick_src(input logic [GSRT_NSRC-1:0] p);
    logic [2:0] s;
    s = 3'h7;
    for (int i = GSRT_NSRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        s = i[2:0];
      end
    end
    return s;
  endfunction

  // status byte per source
  function automatic logic [7:0] stb_of(input logic [2:0] s);
    case (s)
      3'h0: stb_of = GSRT_STB_PWRON;
      3'h1: stb_of = GSRT_STB_ERR;
      3'h2: stb_of = GSRT_STB_STATUS;
      3'h3: stb_of = GSRT_STB_USR1;
      3'h4: stb_of = GSRT_STB_USR2;
      3'h5: stb_of = GSRT_STB_KEY;
      default: stb_of = GSRT_STB_NONE;
    endcase
  endfunction

  // event code per source
  function automatic logic [7:0] evc_of(input logic [2:0] s);
    case (s)
      3'h0: evc_of = GSRT_EVC_PWRON;
      3'h1: evc_of = GSRT_EVC_ERR;
      3'h2: evc_of = GSRT_EVC_STATUS;
      3'h3: evc_of = GSRT_EVC_USR1;
      3'h4: evc_of = GSRT_EVC_USR2;
      3'h5: evc_of = GSRT_EVC_KEY;
      default: evc_of = 8'h00;
    endcase
  endfunction

  // byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [2:0] edges;
    logic [GSRT_NSRC-1:0] evt;
    logic [2:0] src;
    logic [7:0] my_listen;
    logic [7:0] my_talk;
    logic wr_go;
    logic rd_go;
    logic [31:0] wv;
    edges = 3'h0;
    evt = '0;
    src = 3'h7;
    my_listen = 8'h00;
    my_talk = 8'h00;
    wr_go = 1'b0;
    rd_go = 1'b0;
    wv = 32'h0000_0000;
    next_r = r;
    // keys pass two flops, third stage only for edge detect
    next_r.sy1 = {any_key, usr2_key, usr1_key};
    next_r.sy2 = r.sy1;
    next_r.sy3 = r.sy2;
    edges = r.sy2 & ~r.sy3;
    my_listen = GSRT_LISTEN_BASE + {3'h0, addr_sw}; // R19
    my_talk = GSRT_TALK_BASE + {3'h0, addr_sw}; // R19
    // addressing and interface messages
    if (bus_cmd_stb) begin
      if (bus_cmd == my_listen) begin
        next_r.listen = 1'b1;
      end else if (bus_cmd == GSRT_UNL) begin
        next_r.listen = 1'b0;
      end
      if (bus_cmd == my_talk) begin
        next_r.talk = 1'b1;
      end else if (bus_cmd == GSRT_UNT || bus_cmd[7:5] == 3'b010) begin
        next_r.talk = 1'b0;
      end
      if (bus_cmd == GSRT_SPE) begin
        next_r.sp_mode = 1'b1; // R01
      end
      if (bus_cmd == GSRT_SPD) begin
        next_r.sp_mode = 1'b0; // R02
      end
      // trigger needs setup and listener state
      if (bus_cmd == GSRT_GET && r.listen && r.trig_armed) begin // R05 R06
        next_r.acq = gsrt_acq_t'(r.trig_state); // R07
      end
    end
    // event sources; key events gated by masks
    evt[1] = err_evt;
    evt[2] = status_evt;
    evt[3] = edges[0] & r.ctrl[GSRT_CTRL_USR1_BIT]; // R14
    evt[4] = edges[1] & r.ctrl[GSRT_CTRL_USR2_BIT]; // R14
    evt[5] = edges[2] & r.ctrl[GSRT_CTRL_ANY_BIT]; // R16
    // device clear keeps only the power-on event
    if (bus_cmd_stb && (bus_cmd == GSRT_DCL || (bus_cmd == GSRT_SDC && r.listen))) begin
      next_r.pend = r.pend & 6'b000001; // R20
      next_r.srq = r.srq & (r.cur_src == 3'h0); // R20
    end
    // latch status byte at start of a poll read
    if (r.sp_mode && r.talk && talk_rd_start) begin
      next_r.stb_hold = r.srq ? stb_of(r.cur_src) : GSRT_STB_NONE; // R21 R10 R15
    end
    // poll read done: release line and retire the event
    if (r.sp_mode && r.talk && talk_rd_done && r.srq) begin
      next_r.srq = 1'b0; // R03
      next_r.pend[r.cur_src] = 1'b0;
      next_r.last_src = r.cur_src;
      next_r.last_evc = evc_of(r.cur_src);
    end
    // new events win over the retire in the same cycle
    next_r.pend = next_r.pend | evt;
    // raise again for each pending request; no raise while disabled
    src = pick_src(next_r.pend);
    if (!r.srq && !next_r.srq && src != 3'h7 && r.ctrl[GSRT_CTRL_RQS_BIT]
        && !(r.sp_mode && r.talk && talk_rd_done)) begin
      next_r.srq = 1'b1; // R08 R11
      next_r.cur_src = src;
    end
    // talker output: status byte or normal data, never waits on srq
    next_r.out = (r.sp_mode) ? next_r.stb_hold : resp_data; // R01 R02 R12
    // axi write path
    if (s_axi_awvalid && !r.aw_got) begin
      next_r.aw_got = 1'b1;
      next_r.aw_a = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !r.w_got) begin
      next_r.w_got = 1'b1;
      next_r.w_d = s_axi_wdata;
      next_r.w_s = s_axi_wstrb;
    end
    wr_go = r.aw_got && r.w_got && !r.bvalid;
    if (wr_go) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = 2'b00;
      case (r.aw_a)
        GSRT_CTRL_OFS: begin
          next_r.ctrl = merge(r.ctrl, r.w_d, r.w_s) & 32'h0000_001F;
        end
        GSRT_TRIG_OFS: begin
          wv = merge({30'h0, r.trig_state}, r.w_d, r.w_s);
          if (wv[1:0] != 2'b11) begin
            next_r.trig_state = wv[1:0]; // R07
            next_r.trig_armed = wv[4]; // R05
          end else begin
            next_r.bresp = 2'b10;
          end
        end
        default: begin
          next_r.bresp = 2'b10;
        end
      endcase
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    // axi read path
    rd_go = s_axi_arvalid && !r.rvalid;
    if (rd_go) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = 2'b00;
      case (s_axi_araddr[7:0])
        GSRT_CTRL_OFS: next_r.rdata = r.ctrl | {19'h0, addr_sw, 8'h00};
        GSRT_TRIG_OFS: next_r.rdata = {27'h0, r.trig_armed, 2'b00, r.trig_state};
        GSRT_STAT_OFS: next_r.rdata = {16'h0, 2'b00, r.pend, r.srq, r.sp_mode,
                                       r.listen, r.talk, 2'b00, r.acq};
        GSRT_EVENT_OFS: next_r.rdata = {r.ctrl[GSRT_CTRL_VERB_BIT], 15'h0,
                                        5'h0, r.last_src, r.last_evc}; // R13
        GSRT_EVTRIG_OFS: next_r.rdata = {24'h0, stb_of(r.last_src)};
        default: begin
          next_r.rdata = 32'h0000_0000;
          next_r.rresp = 2'b10;
        end
      endcase
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register; reset starts with power-on event pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.ctrl <= GSRT_CTRL_RESET; // R09
      r.pend <= 6'b000001;
      r.cur_src <= 3'h7;
      r.last_src <= 3'h7;
      r.acq <= GSRT_ACQ_STOP;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign talk_data = r.out;
  assign srq_o = r.srq;
  assign srq_oe_n = ~r.srq;
  assign ppr_oe_n = 1'b1; // R04
  assign acq_state = r.acq;
  assign listening = r.listen;
  assign talking = r.talk;
  assign s_axi_awready = !r.aw_got;
  assign s_axi_wready = !r.w_got;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
endmodule

/* verification/gsrt_ctl_model.sv */
// bus controller model: sends interface messages and runs serial polls
// assumes the device shows a poll byte two cycles after the byte start
module gsrt_ctl_model (
  input wire logic aclk, // device clock
  input wire logic [7:0] talk_data, // byte from device
  output logic [7:0] bus_cmd, // message byte
  output logic bus_cmd_stb, // message strobe
  output logic talk_rd_start, // byte start
  output logic talk_rd_done // byte done
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    bus_cmd = 8'h00;
    bus_cmd_stb = 1'b0;
    talk_rd_start = 1'b0;
    talk_rd_done = 1'b0;
  end
  // one interface message; byte lines inverted outside the strobe
  task automatic send(input logic [7:0] c);
    @(posedge aclk);
    bus_cmd <= c;
    bus_cmd_stb <= 1'b1;
    @(posedge aclk);
    bus_cmd <= ~c;
    bus_cmd_stb <= 1'b0;
  endtask
  // one poll read; done comes late so the held byte is exercised
  task automatic poll(output logic [7:0] b);
    @(posedge aclk);
    talk_rd_start <= 1'b1;
    @(posedge aclk);
    talk_rd_start <= 1'b0;
    repeat (2) @(posedge aclk);
    b = talk_data;
    talk_rd_done <= 1'b1;
    @(posedge aclk);
    talk_rd_done <= 1'b0;
  endtask
endmodule

/* verification/gsrt_monitor.sv */
// checker for the service request, poll and trigger block at its top ports
// assumes one clock domain and sync active-low reset; bound at the foot
module gsrt_monitor
  import gsrt_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [7:0] bus_cmd, // message byte
  input wire logic bus_cmd_stb, // message strobe
  input wire logic talk_rd_start, // byte start
  input wire logic talk_rd_done, // byte done
  input wire logic [7:0] resp_data, // normal byte
  input wire logic [7:0] talk_data, // byte on bus
  input wire logic srq_o, // request line
  input wire logic srq_oe_n, // request enable
  input wire logic ppr_oe_n, // poll response enable
  input wire logic [4:0] addr_sw, // switches
  input wire gsrt_pkg::gsrt_acq_t acq_state, // acquisition state
  input wire logic listening, // listener
  input wire logic talking // talker
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sp_q, sp_d, up;
  logic [7:0] la, ta;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // own addresses from the switches
  assign la = GSRT_LISTEN_BASE + {3'h0, addr_sw};
  assign ta = GSRT_TALK_BASE + {3'h0, addr_sw};
  // poll mode mirrored from messages; sp_d tells which mode fed talk_data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_q <= 1'b0;
      sp_d <= 1'b0;
      up <= 1'b0;
    end else begin
      up <= 1'b1;
      sp_d <= sp_q;
      if (bus_cmd_stb && bus_cmd == GSRT_SPE) sp_q <= 1'b1;
      else if (bus_cmd_stb && bus_cmd == GSRT_SPD) sp_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  ppr_idle_a: assert property (ppr_oe_n) else $error("poll response driven");
  srq_pin_a: assert property (srq_oe_n == !srq_o) else $error("srq enable wrong");
  srq_drop_a: assert property ($fell(srq_o) |-> $past(talk_rd_done) ||
    $past(talk_rd_done, 2) || $past(bus_cmd_stb) || $past(bus_cmd_stb, 2))
    else $error("srq fell without poll or clear");
  pwron_req_a: assert property ($rose(aresetn) |-> ##[1:3] srq_o)
    else $error("no power-on request");
  listen_addr_a: assert property (bus_cmd_stb && bus_cmd == la |=> listening)
    else $error("listen address missed");
  talk_addr_a: assert property (bus_cmd_stb && bus_cmd == ta |=> talking)
    else $error("talk address missed");
  unlisten_a: assert property (bus_cmd_stb && bus_cmd == GSRT_UNL |=> !listening)
    else $error("unlisten ignored");
  get_unlisten_a: assert property (bus_cmd_stb && bus_cmd == GSRT_GET && !listening
    |=> $stable(acq_state)[*2]) else $error("trigger taken while not listener");
  normal_data_a: assert property (up && !sp_q && !sp_d |-> talk_data == $past(resp_data))
    else $error("normal byte not passed");
  poll_byte_a: assert property (talk_rd_start && sp_q && talking && srq_o
    |-> ##2 talk_data[6]) else $error("status byte lacks request flag");
endmodule
bind gsrt_top gsrt_monitor mon (.*);

/* verification/test_gpib_service_request_and_trigger.sv */
// self-checking bench for the service request, poll and trigger block
// assumes the controller model drives the bus side, AXI4-Lite the registers
module test_gpib_service_request_and_trigger
  import gsrt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [33:0] WM = 34'h3_0000_0000;
  localparam logic [33:0] FM = 34'h3_FFFF_FFFF;
  integer seed;
  int err_total, cmp_count;
  logic [33:0] qe[$], qm[$];
  logic [2:0] keys;
  logic [7:0] b, e, bus_cmd, resp_data, talk_data;
  logic [4:0] addr_sw;
  logic aclk, aresetn, bus_cmd_stb, talk_rd_start, talk_rd_done, srq_o, srq_oe_n, ppr_oe_n;
  logic err_evt, status_evt, listening, talking;
  gsrt_acq_t acq_state;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic usr1_key, usr2_key, any_key;
  assign {any_key, usr2_key, usr1_key} = keys;
  gsrt_top dut (.*);
  gsrt_ctl_model ctl (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one register access; the watcher compares the answer against the note
  task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rr, input logic [33:0] m);
    int n;
    qe.push_back({rr, d} & m);
    qm.push_back(m);
    s_axi_awaddr <= {24'h0, a};
    s_axi_araddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 50);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    // idle edge so the next call never reassigns a strobe in this step
    @(posedge aclk);
    if (n == 50) chk("axi answer", 34'h0, 34'h1);
    if (n == 50) stop_test;
  endtask
  task automatic wsrq(input logic v);
    int n;
    n = 0;
    while (srq_o !== v && n < 60) begin
      @(posedge aclk);
      n++;
    end
    chk("srq_o", {33'h0, srq_o}, {33'h0, v});
    if (n == 60) stop_test;
  endtask
  task automatic sendw(input logic [7:0] c);
    ctl.send(c);
    repeat (2) @(posedge aclk);
  endtask
  task automatic pulse_err;
    err_evt <= 1'b1;
    @(posedge aclk);
    err_evt <= 1'b0;
  endtask
  // a poll under poll mode; the byte must carry the event type
  task automatic pollx(input logic [7:0] x);
    sendw(GSRT_SPE);
    ctl.poll(b);
    chk("status byte", {26'h0, b}, {26'h0, x});
    sendw(GSRT_SPD);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // clock, and random normal response bytes every cycle
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) resp_data <= 8'($random(seed));
  // answers appear on bvalid or rvalid; compare with the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk("rdata", {s_axi_rresp, s_axi_rdata} & qm.pop_front(), qe.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {s_axi_bresp, 32'h0} & qm.pop_front(), qe.pop_front());
  end
  initial begin
    seed = 32'h2C0C173B;
    aresetn = 1'b0;
    {err_evt, status_evt, keys} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    addr_sw = 5'($random(seed)) & 5'h1E;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    ax(1'b0, GSRT_CTRL_OFS, {19'h0, addr_sw, 8'h01}, 2'b00, FM);
    ax(1'b0, 8'h40, 32'h0, 2'b10, FM);
    wsrq(1'b1);
    $display("test reset done");
    // addressing, ignored parallel poll, poll of the power-on event
    sendw(GSRT_LISTEN_BASE + {3'h0, addr_sw});
    chk("listening", {33'h0, listening}, 34'h1);
    sendw(GSRT_PPC);
    chk("ppr_oe_n", {33'h0, ppr_oe_n}, 34'h1);
    sendw(GSRT_TALK_BASE + {3'h0, addr_sw});
    pollx(GSRT_STB_PWRON);
    wsrq(1'b0);
    @(posedge aclk);
    e = resp_data;
    @(posedge aclk);
    chk("normal byte", {26'h0, talk_data}, {26'h0, e});
    $display("test poll done");
    // two events at once: one request each, then code and verbose flag
    err_evt <= 1'b1;
    status_evt <= 1'b1;
    @(posedge aclk);
    {err_evt, status_evt} <= 2'b00;
    wsrq(1'b1);
    pollx(GSRT_STB_ERR);
    wsrq(1'b1);
    pollx(GSRT_STB_STATUS);
    ax(1'b0, GSRT_EVENT_OFS, {24'h0, GSRT_EVC_STATUS}, 2'b00, 34'h3_8000_00FF);
    ax(1'b1, GSRT_CTRL_OFS, 32'h11, 2'b00, WM);
    ax(1'b0, GSRT_EVENT_OFS, {24'h800000, GSRT_EVC_STATUS}, 2'b00, 34'h3_8000_00FF);
    $display("test events done");
    // request enable off holds back the line; traffic goes on
    ax(1'b1, GSRT_CTRL_OFS, 32'h0, 2'b00, WM);
    pulse_err;
    repeat (8) @(posedge aclk);
    chk("srq off", {33'h0, srq_o}, 34'h0);
    ax(1'b0, GSRT_CTRL_OFS, {19'h0, addr_sw, 8'h00}, 2'b00, FM);
    ax(1'b1, GSRT_CTRL_OFS, 32'h1, 2'b00, WM);
    wsrq(1'b1);
    pollx(GSRT_STB_ERR);
    $display("test enable done");
    // each key unmasked then masked; unique byte per key
    for (int i = 0; i < 3; i++) begin
      ax(1'b1, GSRT_CTRL_OFS, 32'h1, 2'b00, WM);
      keys <= 3'h1 << i;
      repeat (4) @(posedge aclk);
      keys <= 3'h0;
      repeat (8) @(posedge aclk);
      chk("key unmasked", {33'h0, srq_o}, 34'h0);
      ax(1'b1, GSRT_CTRL_OFS, 32'h1 | (32'h2 << i), 2'b00, WM);
      keys <= 3'h1 << i;
      wsrq(1'b1);
      keys <= 3'h0;
      pollx(GSRT_STB_USR1 + 8'(i));
    end
    $display("test keys done");
    // trigger: unarmed, bad state, not listener, then every state
    ax(1'b1, GSRT_TRIG_OFS, 32'h1, 2'b00, WM);
    sendw(GSRT_GET);
    chk("acq unarmed", {32'h0, acq_state}, {32'h0, GSRT_ACQ_STOP});
    ax(1'b1, GSRT_TRIG_OFS, 32'h3, 2'b10, WM);
    ax(1'b1, GSRT_TRIG_OFS, 32'h12, 2'b00, WM);
    sendw(GSRT_UNL);
    sendw(GSRT_GET);
    chk("acq unlistened", {32'h0, acq_state}, {32'h0, GSRT_ACQ_STOP});
    sendw(GSRT_LISTEN_BASE + {3'h0, addr_sw});
    for (int k = 2; k >= 0; k--) begin
      ax(1'b1, GSRT_TRIG_OFS, {27'h0, 1'b1, 2'h0, 2'(k)}, 2'b00, WM);
      sendw(GSRT_GET);
      chk("acq", {32'h0, acq_state}, {32'h0, 2'(k)});
    end
    $display("test trigger done");
    // clear drops an error request but keeps the power-on one
    pulse_err;
    wsrq(1'b1);
    sendw(GSRT_DCL);
    wsrq(1'b0);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    wsrq(1'b1);
    sendw(GSRT_DCL);
    repeat (4) @(posedge aclk);
    chk("srq kept", {33'h0, srq_o}, 34'h1);
    $display("test clear done");
    stop_test;
  end
endmodule
